// ==== check_capture.sv ====
`timescale 1ns/1ps

// Holds the received header check until the next header completes
module check_capture
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hdr_done,
	input wire logic [15:0] check_in,
	output logic [15:0] check_q,
	output logic done_q
);

	// Latch check and flag completion on the same edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			check_q <= {hdr_pkg::RST_BYTE, hdr_pkg::RST_BYTE};
			done_q <= 1'b0;
		end
		else
		begin
			if (hdr_done)
				check_q <= check_in; // [R10]
			done_q <= hdr_done; // [R10]
		end
	end

endmodule // check_capture

// ==== delim_join.sv ====
`timescale 1ns/1ps

// Joins the two delimiter bytes into one word
module delim_join
(
	input wire logic [7:0] high_byte,
	input wire logic [7:0] low_byte,
	output logic [15:0] delim
);

	// High byte on top
	assign delim = {high_byte, low_byte}; // [R06]

endmodule // delim_join

// ==== hdr_asserts.sv ====
`timescale 1ns/1ps

// Port-level checks on the header field registers
module hdr_asserts
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic rx_hdr_done,
	input wire logic rx_hdr_ready_q,
	input wire logic [15:0] delimiter_q,
	input wire logic [1:0] hdr_mode_q,
	input wire logic check_delim_q,
	input wire logic check_length_q,
	input wire logic check_rest_q
);
	// Write data taken this cycle
	logic w_hs;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	mode_none_a: assert property (hdr_mode_q == 2'h0
		|-> !check_delim_q && !check_length_q && !check_rest_q)
		else $error("coverage set in mode 0");
	mode_delim_a: assert property (hdr_mode_q == 2'h1
		|-> check_delim_q && !check_length_q && !check_rest_q)
		else $error("mode 1 coverage wrong");
	mode_len_a: assert property (hdr_mode_q == 2'h2
		|-> check_delim_q && check_length_q && !check_rest_q)
		else $error("mode 2 coverage wrong");
	mode_all_a: assert property (hdr_mode_q == 2'h3
		|-> check_delim_q && check_length_q && check_rest_q)
		else $error("mode 3 coverage wrong");
	ready_delay_a: assert property (rx_hdr_done
		|-> ##2 rx_hdr_ready_q)
		else $error("capture ready late");
	ready_cause_a: assert property (rx_hdr_ready_q
		|-> $past(rx_hdr_done, 2))
		else $error("capture ready without header");
	write_busy_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	wdata_taken_a: assert property (w_hs |=> !s_axi_wready)
		else $error("write data slot offered while held");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	rdata_byte_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read upper bits not zero");
	delim_write_a: assert property ($changed(delimiter_q)
		|-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("delimiter changed without write");
endmodule // hdr_asserts

bind header_field_registers hdr_asserts i_hdr_asserts
(
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata),
	.rx_hdr_done(rx_hdr_done),
	.rx_hdr_ready_q(rx_hdr_ready_q),
	.delimiter_q(delimiter_q),
	.hdr_mode_q(hdr_mode_q),
	.check_delim_q(check_delim_q),
	.check_length_q(check_length_q),
	.check_rest_q(check_rest_q)
);

// ==== hdr_pkg.sv ====
package hdr_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CHECK_HIGH = 8'hBC;
	localparam logic [7:0] OFF_CHECK_LOW = 8'hC0;
	localparam logic [7:0] OFF_DELIM_HIGH = 8'hC4;
	localparam logic [7:0] OFF_DELIM_LOW = 8'hC8;
	localparam logic [7:0] OFF_SERVICE = 8'hCC;
	localparam logic [7:0] OFF_LEN_HIGH = 8'hD0;
	localparam logic [7:0] OFF_LEN_LOW = 8'hD4;
	localparam logic [7:0] OFF_HDR_MODE = 8'h08;

	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;

	// Header check coverage modes
	typedef enum logic [1:0]
	{
		MODE_NONE = 2'b00,
		MODE_DELIM = 2'b01,
		MODE_DELIM_LEN = 2'b10,
		MODE_ALL = 2'b11
	} hdr_mode_t;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== header_field_registers.sv ====
// Overview of operation
// [R01] Upper received check byte readable
// [R02] Lower received check byte readable
// [R03] Check coverage follows selected mode
// [R04] Writable delimiter high byte, tx and rx
// [R05] Writable delimiter low byte
// [R06] Join delimiter bytes into one word
// [R07] Service register sent as service byte
// [R08] Writable transmit length upper byte
// [R09] Mode bits select checked fields
// [R10] Latch check on the completion edge, hold
`timescale 1ns/1ps

module header_field_registers
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_hdr_done,
	input wire logic [15:0] received_header_check,
	output logic rx_hdr_ready_q,
	output logic [15:0] delimiter_q,
	output logic [7:0] tx_service_q,
	output logic [7:0] tx_length_high_q,
	output logic [1:0] hdr_mode_q,
	output logic check_delim_q,
	output logic check_length_q,
	output logic check_rest_q
);

	// Register storage
	logic [7:0] delim_high_q; // Delimiter high byte
	logic [7:0] delim_low_q; // Delimiter low byte
	logic [7:0] service_q; // Service byte
	logic [7:0] len_high_q; // Length high byte
	logic [7:0] len_low_q; // Length low byte, owned by neighbour
	hdr_pkg::hdr_mode_t mode_q; // Header mode
	logic [15:0] check_q; // Captured check
	logic done_q; // Capture complete
	logic [15:0] delim_w; // Joined delimiter

	// Write channel holding
	logic [7:0] aw_addr_q;
	logic aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_have_q;
	logic do_write; // Both halves held, commit now
	logic aw_fire; // Address handshake
	logic w_fire; // Data handshake

	// Handshakes and the write commit strobe
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	// Received check holder
	check_capture u_cap
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.hdr_done(rx_hdr_done),
		.check_in(received_header_check),
		.check_q(check_q),
		.done_q(done_q)
	);

	// Delimiter assembly
	delim_join u_join
	(
		.high_byte(delim_high_q),
		.low_byte(delim_low_q),
		.delim(delim_w)
	);

	// Address capture, either order with data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			// Offer the slot only while nothing is held
			s_axi_awready <= !aw_have_q && !aw_fire && !s_axi_bvalid;
			if (aw_fire)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			// Free the slot once the write commits
			else if (do_write)
				aw_have_q <= 1'b0;
		end
	end

	// Data capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			// Offer the slot only while nothing is held
			s_axi_wready <= !w_have_q && !w_fire && !s_axi_bvalid;
			if (w_fire)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			// Free the slot once the write commits
			else if (do_write)
				w_have_q <= 1'b0;
		end
	end

	// Register writes, low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			delim_high_q <= hdr_pkg::RST_BYTE;
			delim_low_q <= hdr_pkg::RST_BYTE;
			service_q <= hdr_pkg::RST_BYTE;
			len_high_q <= hdr_pkg::RST_BYTE;
			len_low_q <= hdr_pkg::RST_BYTE;
			mode_q <= hdr_pkg::MODE_NONE;
		end
		else if (do_write && w_strb_q[0])
		begin
			// Registers are at most one byte wide; upper lanes are dropped
			case (aw_addr_q)
				hdr_pkg::OFF_DELIM_HIGH:
					delim_high_q <= w_data_q[7:0]; // [R04]
				hdr_pkg::OFF_DELIM_LOW:
					delim_low_q <= w_data_q[7:0]; // [R05]
				hdr_pkg::OFF_SERVICE:
					service_q <= w_data_q[7:0]; // [R07]
				hdr_pkg::OFF_LEN_HIGH:
					len_high_q <= w_data_q[7:0]; // [R08]
				hdr_pkg::OFF_LEN_LOW:
					len_low_q <= w_data_q[7:0];
				hdr_pkg::OFF_HDR_MODE:
					mode_q <= hdr_pkg::hdr_mode_t'(w_data_q[1:0]); // [R09]
				// Check registers are read-only, writes fall through
				default:
					;
			endcase
		end
	end

	// Write response, unmapped gets SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= hdr_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_q)
				hdr_pkg::OFF_DELIM_HIGH, hdr_pkg::OFF_DELIM_LOW,
				hdr_pkg::OFF_SERVICE, hdr_pkg::OFF_LEN_HIGH,
				hdr_pkg::OFF_LEN_LOW, hdr_pkg::OFF_HDR_MODE,
				hdr_pkg::OFF_CHECK_HIGH, hdr_pkg::OFF_CHECK_LOW:
					s_axi_bresp <= hdr_pkg::RESP_OKAY;
				default:
					s_axi_bresp <= hdr_pkg::RESP_SLVERR;
			endcase
		end
		// Response stands until the master takes it
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read channel, one cycle after address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= hdr_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= hdr_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			case (s_axi_araddr)
				hdr_pkg::OFF_CHECK_HIGH:
					s_axi_rdata[7:0] <= check_q[15:8]; // [R01]
				hdr_pkg::OFF_CHECK_LOW:
					s_axi_rdata[7:0] <= check_q[7:0]; // [R02]
				hdr_pkg::OFF_DELIM_HIGH:
					s_axi_rdata[7:0] <= delim_high_q;
				hdr_pkg::OFF_DELIM_LOW:
					s_axi_rdata[7:0] <= delim_low_q;
				hdr_pkg::OFF_SERVICE:
					s_axi_rdata[7:0] <= service_q;
				hdr_pkg::OFF_LEN_HIGH:
					s_axi_rdata[7:0] <= len_high_q;
				hdr_pkg::OFF_LEN_LOW:
					s_axi_rdata[7:0] <= len_low_q;
				hdr_pkg::OFF_HDR_MODE:
					s_axi_rdata[1:0] <= mode_q;
				// Unmapped: zero data with an error
				default:
					s_axi_rresp <= hdr_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_rvalid)
		begin
			// Hold until master takes it
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		// Idle again: offer the address channel
		else
			s_axi_arready <= 1'b1;
	end

	// Header field outputs and check coverage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			delimiter_q <= {hdr_pkg::RST_BYTE, hdr_pkg::RST_BYTE};
			tx_service_q <= hdr_pkg::RST_BYTE;
			tx_length_high_q <= hdr_pkg::RST_BYTE;
			hdr_mode_q <= hdr_pkg::RST_MODE;
			check_delim_q <= 1'b0;
			check_length_q <= 1'b0;
			check_rest_q <= 1'b0;
			rx_hdr_ready_q <= 1'b0;
		end
		else
		begin
			// Registered copies, so every output leaves a flop
			delimiter_q <= delim_w; // [R06]
			tx_service_q <= service_q; // [R07]
			tx_length_high_q <= len_high_q; // [R08]
			hdr_mode_q <= mode_q; // [R09]
			rx_hdr_ready_q <= done_q; // [R10]
			// Coverage per mode
			case (mode_q)
				hdr_pkg::MODE_NONE:
				begin
					check_delim_q <= 1'b0; // [R03]
					check_length_q <= 1'b0;
					check_rest_q <= 1'b0;
				end
				hdr_pkg::MODE_DELIM:
				begin
					check_delim_q <= 1'b1; // [R03]
					check_length_q <= 1'b0;
					check_rest_q <= 1'b0;
				end
				hdr_pkg::MODE_DELIM_LEN:
				begin
					check_delim_q <= 1'b1; // [R03]
					check_length_q <= 1'b1;
					check_rest_q <= 1'b0;
				end
				// Mode 3: every header field covered
				default:
				begin
					check_delim_q <= 1'b1; // [R03]
					check_length_q <= 1'b1;
					check_rest_q <= 1'b1;
				end
			endcase
		end
	end

endmodule // header_field_registers

// ==== rx_source.sv ====
`timescale 1ns/1ps

// Receiver stand-in: header done pulse with its check value
module rx_source
(
	input wire logic aclk,
	input wire logic send,
	input wire logic [15:0] value,
	output logic rx_hdr_done,
	output logic [15:0] received_header_check
);
	// Check is valid only with done; otherwise inverted
	always_ff @(posedge aclk)
	begin
		rx_hdr_done <= send;
		received_header_check <= send ? value : ~received_header_check;
	end
endmodule // rx_source

// ==== testbench.sv ====
`timescale 1ns/1ps

module testbench;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0;
	logic rrdy = 0, send = 0, hd, rdy, bv, rv, awr, wr, arr, cd, cl, cr;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [15:0] val = 0, chk, dl;
	logic [7:0] sv, lh;
	logic [1:0] br, rr, md;
	int fail_count = 0, num_checks = 0, n, m;
	localparam logic [1:0] OK_RESP = hdr_pkg::RESP_OKAY;
	localparam logic [1:0] ERR_RESP = hdr_pkg::RESP_SLVERR;
	header_field_registers i_header_field_registers (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.rx_hdr_done(hd), .received_header_check(chk),
		.rx_hdr_ready_q(rdy), .delimiter_q(dl), .tx_service_q(sv),
		.tx_length_high_q(lh), .hdr_mode_q(md), .check_delim_q(cd),
		.check_length_q(cl), .check_rest_q(cr));
	rx_source i_rx_source (.aclk(aclk), .send(send), .value(val),
		.rx_hdr_done(hd), .received_header_check(chk));
	initial forever #12.5 aclk = ~aclk;
	task close_out;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Ends the run when a bounded wait ran out
	task limit;
		if (n >= 50)
		begin
			fail_count++;
			$display("[FAIL] %0t wait ran out", $time);
			close_out;
		end
	endtask
	// AXI4-Lite write, address and data offered together
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			if (bv) break;
		end
		limit;
		cmp(br, e);
		brdy <= 0;
	endtask
	// AXI4-Lite read with expected byte and response
	task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		ara <= a; arv <= 1; rrdy <= 1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arr) arv <= 0;
			if (rv) break;
		end
		limit;
		cmp(rd, e);
		cmp(rr, r);
		rrdy <= 0;
	endtask
	// Sends one header and waits for the capture flag
	task header(input logic [15:0] v);
		@(posedge aclk);
		val <= v; send <= 1;
		@(posedge aclk);
		send <= 0;
		for (n = 0; n < 50 && !rdy; n++) @(posedge aclk);
		limit;
		cmp(n, 3);
		@(posedge aclk);
		cmp(rdy, 1'b0);
	endtask
	// Outputs and registers straight after a reset
	task reset_values;
		cmp({dl, sv, lh}, 32'h0000_0000);
		cmp({md, cd, cl, cr, rdy}, 32'h0000_0000);
		axr(hdr_pkg::OFF_CHECK_HIGH, 32'h0, OK_RESP);
		axr(hdr_pkg::OFF_CHECK_LOW, 32'h0, OK_RESP);
		axr(hdr_pkg::OFF_DELIM_LOW, 32'h0, OK_RESP);
		axr(8'h40, 32'h0, ERR_RESP);
	endtask
	// Both delimiter bytes written, read back and joined
	task delimiter;
		axw(hdr_pkg::OFF_DELIM_HIGH, 32'h1234_56A5, OK_RESP);
		axw(hdr_pkg::OFF_DELIM_LOW, 32'h0000_003C, OK_RESP);
		axr(hdr_pkg::OFF_DELIM_HIGH, 32'h0000_00A5, OK_RESP);
		axr(hdr_pkg::OFF_DELIM_LOW, 32'h0000_003C, OK_RESP);
		cmp(dl, 32'h0000_A53C);
	endtask
	// Service byte kept at zero, length bytes written and read back
	task service_length;
		axw(hdr_pkg::OFF_SERVICE, 32'h0, OK_RESP);
		axr(hdr_pkg::OFF_SERVICE, 32'h0, OK_RESP);
		axw(hdr_pkg::OFF_LEN_HIGH, 32'h0000_009B, OK_RESP);
		axw(hdr_pkg::OFF_LEN_LOW, 32'h0000_0061, OK_RESP);
		axr(hdr_pkg::OFF_LEN_HIGH, 32'h0000_009B, OK_RESP);
		axr(hdr_pkg::OFF_LEN_LOW, 32'h0000_0061, OK_RESP);
		cmp(sv, 32'h0);
		cmp(lh, 32'h0000_009B);
	endtask
	// Every mode code from 3 down, its echo and the covered fields
	task mode_coverage;
		for (m = 3; m >= 0; m--)
		begin
			axw(hdr_pkg::OFF_HDR_MODE, m, OK_RESP);
			@(posedge aclk);
			cmp(md, m);
			cmp({cd, cl, cr}, {m > 0, m > 1, m > 2});
			axr(hdr_pkg::OFF_HDR_MODE, m, OK_RESP);
		end
	endtask
	// Check captured, readable once flagged, kept until the next header
	task capture;
		header(16'hBEEF);
		axr(hdr_pkg::OFF_CHECK_HIGH, 32'h0000_00BE, OK_RESP);
		axr(hdr_pkg::OFF_CHECK_LOW, 32'h0000_00EF, OK_RESP);
		axw(hdr_pkg::OFF_CHECK_HIGH, 32'h0000_0011, OK_RESP);
		axr(hdr_pkg::OFF_CHECK_HIGH, 32'h0000_00BE, OK_RESP);
		header(16'h1357);
		axr(hdr_pkg::OFF_CHECK_HIGH, 32'h0000_0013, OK_RESP);
		axr(hdr_pkg::OFF_CHECK_LOW, 32'h0000_0057, OK_RESP);
	endtask
	// Reset in mid-run clears every output and every register read back; length low, service and mode are not read
	task mid_reset;
		@(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		reset_values;
		axr(hdr_pkg::OFF_DELIM_HIGH, 32'h0, OK_RESP);
		axr(hdr_pkg::OFF_LEN_HIGH, 32'h0, OK_RESP);
	endtask
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		reset_values;
		delimiter;
		service_length;
		mode_coverage;
		capture;
		mid_reset;
		close_out;
	end
endmodule // testbench
